// File: rtl/cdb_bridge_deadband.v
// Operation
// - two independent 6-bit dead-band counters
// - rise counter: half-bridge rising edge, full-bridge reverse change
// - fall counter: half-bridge falling edge, full-bridge forward change
// - count clock periods from zero up to programmed value
// - half-bridge: delay from phase A fall to phase B rise
// - full-bridge: dead band only on direction change
// - direction bit writable while running
// - phases A and C switch on first input rise after change
// - modulated phase B or D held off for dead band after change
// - rise value delays A (half) or B (full) leading edge
// - rise value loads immediately while disabled
// - enabled: load request applies buffer on next input fall
// - input too short for count leaves output inactive
// - fall value delays B (half) or D (full), same buffering
`timescale 1ns/1ps
`include "cdb_consts.vh"
`default_nettype none
module cdb_bridge_deadband
(
    // clock and reset
    input  wire                    clk_sys_i,
    input  wire                    sys_rst_i,
    // register port
    input  wire [`CDB_ADDR_W-1:0]  reg_addr_i,
    input  wire [`CDB_DATA_W-1:0]  reg_wdata_i,
    input  wire                    reg_wr_i,
    input  wire                    reg_rd_i,
    output reg  [`CDB_DATA_W-1:0]  reg_rdata_o,
    // input source
    input  wire                    src_i,
    // bridge outputs
    output reg                     out_phase_a_o,
    output reg                     out_phase_b_o,
    output reg                     out_phase_c_o,
    output reg                     out_phase_d_o
);
    // ****************************************
    // registers
    // ****************************************
    reg                  en_reg;
    reg                  full_reg;
    reg                  dir_reg;
    reg                  ld_reg;
    reg [`CDB_CNT_W-1:0] rise_buf_reg;
    reg [`CDB_CNT_W-1:0] fall_buf_reg;
    reg [`CDB_CNT_W-1:0] rise_act_reg;
    reg [`CDB_CNT_W-1:0] fall_act_reg;
    reg                  fwd_act_reg;
    reg                  dir_pend_reg;
    reg                  mod_hold_reg;

    wire src_rise;
    wire src_fall;
    wire rise_busy;
    wire fall_busy;
    wire rise_start;
    wire fall_start;
    wire wr_ctrl;
    wire dir_change_now;

    function wire_sel;
        input [`CDB_ADDR_W-1:0] a;
        input [`CDB_ADDR_W-1:0] b;
        begin
            wire_sel = (a == b);
        end
    endfunction

    assign wr_ctrl = reg_wr_i & wire_sel(reg_addr_i, `CDB_IDX_CTRL);

    cdb_edge_det u_edge
    (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .level_i   (src_i),
        .rise_o    (src_rise),
        .fall_o    (src_fall)
    );

    // ****************************************
    // software writes
    // ****************************************
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            en_reg       <= 1'b0;
            full_reg     <= 1'b0;
            dir_reg      <= 1'b0;
            ld_reg       <= 1'b0;
            rise_buf_reg <= `CDB_DB_RST;
            fall_buf_reg <= `CDB_DB_RST;
            rise_act_reg <= `CDB_DB_RST;
            fall_act_reg <= `CDB_DB_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                en_reg   <= reg_wdata_i[`CDB_BIT_EN];
                full_reg <= reg_wdata_i[`CDB_BIT_FULL];
                dir_reg  <= reg_wdata_i[`CDB_BIT_DIR];
            end
            if (reg_wr_i & wire_sel(reg_addr_i, `CDB_IDX_RISE))
            begin
                rise_buf_reg <= reg_wdata_i[`CDB_CNT_W-1:0];
                if (!en_reg)
                    rise_act_reg <= reg_wdata_i[`CDB_CNT_W-1:0];
            end
            if (reg_wr_i & wire_sel(reg_addr_i, `CDB_IDX_FALL))
            begin
                fall_buf_reg <= reg_wdata_i[`CDB_CNT_W-1:0];
                if (!en_reg)
                    fall_act_reg <= reg_wdata_i[`CDB_CNT_W-1:0];
            end
            // load on input fall; set by software wins over clear
            if (en_reg & ld_reg & src_fall)
            begin
                rise_act_reg <= rise_buf_reg;
                fall_act_reg <= fall_buf_reg;
            end
            if (wr_ctrl & reg_wdata_i[`CDB_BIT_LD] & en_reg)
                ld_reg <= 1'b1;
            else if (src_fall | ~en_reg)
                ld_reg <= 1'b0;
        end
    end

    // ****************************************
    // dead-band counters
    // ****************************************
    assign dir_change_now = full_reg & src_rise & (dir_reg != fwd_act_reg);

    // half: rise starts rise counter, fall starts fall counter
    // full: reverse change uses rise, forward change uses fall
    assign rise_start = en_reg & (full_reg ? (dir_change_now & ~dir_reg)
                                           : src_rise);
    assign fall_start = en_reg & (full_reg ? (dir_change_now & dir_reg)
                                           : src_fall);

    cdb_db_counter u_rise_cnt
    (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (rise_start),
        .abort_i   (~full_reg & src_fall),
        .limit_i   (rise_act_reg),
        .busy_o    (rise_busy),
        .done_o    ()
    );

    cdb_db_counter u_fall_cnt
    (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (fall_start),
        .abort_i   (~full_reg & src_rise),
        .limit_i   (fall_act_reg),
        .busy_o    (fall_busy),
        .done_o    ()
    );

    // ****************************************
    // direction tracking and outputs
    // ****************************************
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            fwd_act_reg   <= 1'b0;
            dir_pend_reg  <= 1'b0;
            mod_hold_reg  <= 1'b0;
            out_phase_a_o <= 1'b0;
            out_phase_b_o <= 1'b0;
            out_phase_c_o <= 1'b0;
            out_phase_d_o <= 1'b0;
        end
        else if (!en_reg)
        begin
            fwd_act_reg   <= dir_reg;
            dir_pend_reg  <= 1'b0;
            mod_hold_reg  <= 1'b0;
            out_phase_a_o <= 1'b0;
            out_phase_b_o <= 1'b0;
            out_phase_c_o <= 1'b0;
            out_phase_d_o <= 1'b0;
        end
        else if (!full_reg)
        begin
            out_phase_a_o <= src_i & ~src_rise & ~rise_busy;
            out_phase_b_o <= ~src_i & ~src_fall & ~fall_busy;
            out_phase_c_o <= 1'b0;
            out_phase_d_o <= 1'b0;
            fwd_act_reg   <= dir_reg;
        end
        else
        begin
            dir_pend_reg <= (dir_reg != fwd_act_reg);
            if (dir_change_now)
            begin
                fwd_act_reg  <= dir_reg;
                mod_hold_reg <= 1'b1;
            end
            else if (mod_hold_reg & ~rise_busy & ~fall_busy)
                mod_hold_reg <= 1'b0;
            // forward: A on, D modulated; reverse: C on, B modulated
            out_phase_a_o <= dir_change_now ? dir_reg : fwd_act_reg;
            out_phase_c_o <= dir_change_now ? ~dir_reg : ~fwd_act_reg;
            out_phase_d_o <= fwd_act_reg & ~dir_change_now & src_i
                             & ~(mod_hold_reg & fall_busy);
            out_phase_b_o <= ~fwd_act_reg & ~dir_change_now & src_i
                             & ~(mod_hold_reg & rise_busy);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            case (reg_addr_i)
                `CDB_IDX_CTRL: reg_rdata_o <= {4'h0, ld_reg, dir_reg,
                                               full_reg, en_reg};
                `CDB_IDX_RISE: reg_rdata_o <= {2'b00, rise_buf_reg};
                `CDB_IDX_FALL: reg_rdata_o <= {2'b00, fall_buf_reg};
                `CDB_IDX_STAT: reg_rdata_o <= {1'b0, dir_pend_reg,
                                               rise_busy, fall_busy,
                                               out_phase_d_o, out_phase_c_o,
                                               out_phase_b_o, out_phase_a_o};
                default:       reg_rdata_o <= 8'h00;
            endcase
        end
        else
            reg_rdata_o <= 8'h00;
    end
endmodule // cdb_bridge_deadband
`default_nettype wire

// File: rtl/cdb_consts.vh
`ifndef CDB_CONSTS_VH
`define CDB_CONSTS_VH
// register indices on the plain port
`define CDB_ADDR_W        2
`define CDB_IDX_CTRL      2'h0
`define CDB_IDX_RISE      2'h1
`define CDB_IDX_FALL      2'h2
`define CDB_IDX_STAT      2'h3
// control register fields
`define CDB_BIT_EN        0
`define CDB_BIT_FULL      1
`define CDB_BIT_DIR       2
`define CDB_BIT_LD        3
// widths and reset values
`define CDB_DATA_W        8
`define CDB_CNT_W         6
`define CDB_DB_RST        6'h00
`define CDB_CTRL_RST      4'h0
`endif

// File: rtl/cdb_db_counter.v
`timescale 1ns/1ps
`include "cdb_consts.vh"
`default_nettype none
module cdb_db_counter
(
    // clock and reset
    input  wire                    clk_sys_i,
    input  wire                    sys_rst_i,
    // control
    input  wire                    start_i,
    input  wire                    abort_i,
    input  wire [`CDB_CNT_W-1:0]   limit_i,
    // status
    output wire                    busy_o,
    output wire                    done_o
);
    reg                  busy_reg;
    reg [`CDB_CNT_W-1:0] cnt_reg;

    // count from zero up to limit; restart on each start
    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i | abort_i)
        begin
            busy_reg <= 1'b0;
            cnt_reg  <= `CDB_DB_RST;
        end
        else if (start_i)
        begin
            busy_reg <= (limit_i != `CDB_DB_RST);
            cnt_reg  <= `CDB_DB_RST;
        end
        else if (busy_reg)
        begin
            if (cnt_reg + 6'h01 == limit_i)
                busy_reg <= 1'b0;
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    assign busy_o = busy_reg | start_i;
    assign done_o = ~busy_o;
endmodule // cdb_db_counter
`default_nettype wire

// File: rtl/cdb_edge_det.v
`timescale 1ns/1ps
`default_nettype none
module cdb_edge_det
(
    // clock and reset
    input  wire clk_sys_i,
    input  wire sys_rst_i,
    // level in, edges out
    input  wire level_i,
    output wire rise_o,
    output wire fall_o
);
    reg last_reg;

    always @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
            last_reg <= 1'b0;
        else
            last_reg <= level_i;
    end

    assign rise_o = level_i & ~last_reg;
    assign fall_o = ~level_i & last_reg;
endmodule // cdb_edge_det
`default_nettype wire

// File: verification/cdb_bridge_deadband_assertions.sv
`timescale 1ns/1ps
`include "cdb_consts.vh"
`default_nettype none
module cdb_chk
(
    // clock and reset
    input wire                   clk_sys_i,
    input wire                   sys_rst_i,
    // register port
    input wire [`CDB_ADDR_W-1:0] reg_addr_i,
    input wire [`CDB_DATA_W-1:0] reg_wdata_i,
    input wire                   reg_wr_i,
    input wire                   reg_rd_i,
    input wire [`CDB_DATA_W-1:0] reg_rdata_o,
    // source and bridge
    input wire                   src_i,
    input wire                   out_phase_a_o,
    input wire                   out_phase_b_o,
    input wire                   out_phase_c_o,
    input wire                   out_phase_d_o
);
// ****************************************
// mirror of control and live values
// ****************************************
reg       en_reg, full_reg, ld_reg, src_reg;
reg [5:0] rb_reg, fb_reg, ra_reg, fa_reg;
reg [6:0] ch_reg, cl_reg;
wire      half = en_reg & ~full_reg;
wire [1:0] ad = reg_addr_i;
always @(posedge clk_sys_i)
begin
    if (sys_rst_i)
    begin
        {en_reg, full_reg, ld_reg, src_reg} <= 4'h0;
        {rb_reg, fb_reg, ra_reg, fa_reg} <= 24'h00_0000;
        {ch_reg, cl_reg} <= 14'h0000;
    end
    else
    begin
        src_reg <= src_i;
        ch_reg <= !src_i ? 7'h00 : ch_reg + {6'h00, ~&ch_reg};
        cl_reg <= src_i ? 7'h00 : cl_reg + {6'h00, ~&cl_reg};
        if (src_reg && !src_i && ld_reg && en_reg)
        begin
            ra_reg <= rb_reg;
            fa_reg <= fb_reg;
        end
        if (reg_wr_i && ad == `CDB_IDX_CTRL)
        begin
            en_reg <= reg_wdata_i[0];
            full_reg <= reg_wdata_i[1];
        end
        // request taken only while running; fall or disable clears it
        if (reg_wr_i && ad == `CDB_IDX_CTRL && reg_wdata_i[3] && en_reg)
            ld_reg <= 1'b1;
        else if ((src_reg && !src_i) || !en_reg)
            ld_reg <= 1'b0;
        if (reg_wr_i && ad == `CDB_IDX_RISE)
            rb_reg <= reg_wdata_i[5:0];
        if (reg_wr_i && ad == `CDB_IDX_RISE && !en_reg)
            ra_reg <= reg_wdata_i[5:0];
        if (reg_wr_i && ad == `CDB_IDX_FALL)
            fb_reg <= reg_wdata_i[5:0];
        if (reg_wr_i && ad == `CDB_IDX_FALL && !en_reg)
            fa_reg <= reg_wdata_i[5:0];
    end
end
// ****************************************
// properties
// ****************************************
default clocking cb @(posedge clk_sys_i); endclocking
default disable iff (sys_rst_i);
sequence src_low3;
    !src_i [*3];
endsequence
a_ab_apart: assert property (!(out_phase_a_o && out_phase_b_o))
    else $error("a and b overlap");
a_cd_apart: assert property (!(out_phase_c_o && out_phase_d_o))
    else $error("c and d overlap");
a_rise_wait: assert property (half && out_phase_a_o && src_i
    |-> ch_reg >= {1'b0, ra_reg}) else $error("a too early");
a_rise_land: assert property (half && src_i
    && ch_reg == {1'b0, ra_reg} + 7'h05 |-> out_phase_a_o)
    else $error("a missing");
a_fall_wait: assert property (half && out_phase_b_o && !src_i
    |-> cl_reg >= {1'b0, fa_reg}) else $error("b too early");
a_fall_land: assert property (half && !src_i
    && cl_reg == {1'b0, fa_reg} + 7'h05 |-> out_phase_b_o)
    else $error("b missing");
a_a_drop: assert property (half ##0 src_low3 |-> !out_phase_a_o)
    else $error("a held low src");
a_dir_on_rise: assert property (en_reg && full_reg && $past(en_reg)
    && $past(full_reg) && $changed(out_phase_a_o) |-> src_i)
    else $error("a moved off rise");
endmodule // cdb_chk
`default_nettype wire

// File: verification/cdb_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdb_switch_model
(
    // clock
    input  wire        clk_sys_i,
    // gate drives, a in bit 0
    input  wire [3:0]  gate_i,
    // rise-edge tallies (a in low byte) and overlap-cycle count
    output reg  [31:0] rises_o,
    output reg  [7:0]  shoot_o
);
reg [3:0] gate_reg = 4'h0;
integer   k;
initial rises_o = 32'h0000_0000;
initial shoot_o = 8'h00;
always @(posedge clk_sys_i)
begin
    gate_reg <= gate_i;
    for (k = 0; k < 4; k = k + 1)
        if (gate_i[k] && !gate_reg[k])
            rises_o[8*k +: 8] <= rises_o[8*k +: 8] + 8'h01;
    // both legs on shorts the rail
    if (&gate_i[1:0] || &gate_i[3:2])
        shoot_o <= shoot_o + 8'h01;
end
endmodule // cdb_switch_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
reg        clk_sys_i = 0, sys_rst_i = 1, wr = 0, rd = 0, src = 0, rd_q = 0;
reg [1:0]  addr = 0, ad;
reg [7:0]  wd = 0, v, exp_q[$];
reg [31:0] seed = 32'hd43f_f156, s;
wire [7:0] rdata, shoot;
wire [3:0] ph;
wire [31:0] rises;
integer    n_errors = 0, check_count = 0, cyc = 0, i;
always #20 clk_sys_i = ~clk_sys_i;
cdb_bridge_deadband dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .src_i(src), .out_phase_a_o(ph[0]),
    .out_phase_b_o(ph[1]), .out_phase_c_o(ph[2]), .out_phase_d_o(ph[3]));
cdb_switch_model sw (.clk_sys_i(clk_sys_i), .gate_i(ph), .rises_o(rises),
    .shoot_o(shoot));
task chk(input [79:0] nm, input [7:0] e, input [7:0] g);
begin
    check_count = check_count + 1;
    if (g !== e)
    begin
        n_errors = n_errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
    end
end
endtask
task final_report;
begin
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
end
endtask
task wreg(input [1:0] a, input [7:0] d);
begin
    @(posedge clk_sys_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
end
endtask
task rreg(input [1:0] a, input [7:0] e);
begin
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    rd <= 1'b0;
end
endtask
task pulse(input integer hi, input integer lo, input integer n);
    integer j;
begin
    // let outputs settle after an enable write before tallying
    repeat (3) @(posedge clk_sys_i);
    s = rises;
    for (j = 0; j < n; j = j + 1)
    begin
        @(posedge clk_sys_i);
        src <= 1'b1;
        repeat (hi) @(posedge clk_sys_i);
        src <= 1'b0;
        repeat (lo - 1) @(posedge clk_sys_i);
    end
end
endtask
task edges(input [7:0] ea, input [7:0] eb, input [7:0] ed);
begin
    chk("rises_a", ea, rises[7:0] - s[7:0]);
    chk("rises_b", eb, rises[15:8] - s[15:8]);
    chk("rises_d", ed, rises[31:24] - s[31:24]);
end
endtask
always @(posedge clk_sys_i)
begin
    rd_q <= rd;
    if (rd_q)
        chk("rdata", exp_q.pop_front(), rdata);
    cyc = cyc + 1;
    if (cyc > 20000)
    begin
        n_errors = n_errors + 1;
        final_report;
    end
end
initial
begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (i = 0; i < 4; i = i + 1)
        rreg(i[1:0], 8'h00);
    for (i = 0; i < 6; i = i + 1)
    begin
        s = $random(seed);
        v = s[7:0];
        ad = 2'h1 + {1'b0, i[0]};
        wreg(ad, v);
        rreg(ad, {2'h0, v[5:0]});
    end
    wreg(2'h3, 8'hff);
    rreg(2'h3, 8'h00);
    wreg(2'h0, 8'h08);
    rreg(2'h0, 8'h00);
    wreg(2'h1, 8'h05);
    wreg(2'h2, 8'h07);
    wreg(2'h0, 8'h01);
    pulse(20, 20, 4);
    edges(8'h04, 8'h04, 8'h00);
    wreg(2'h0, 8'h00);
    wreg(2'h1, 8'h0a);
    wreg(2'h2, 8'h0a);
    wreg(2'h0, 8'h01);
    pulse(4, 4, 6);
    edges(8'h00, 8'h00, 8'h00);
    wreg(2'h1, 8'h02);
    wreg(2'h0, 8'h09);
    rreg(2'h0, 8'h09);
    pulse(20, 20, 1);
    rreg(2'h0, 8'h01);
    pulse(8, 8, 3);
    edges(8'h03, 8'h00, 8'h00);
    wreg(2'h0, 8'h00);
    wreg(2'h1, 8'h03);
    wreg(2'h2, 8'h04);
    wreg(2'h0, 8'h07);
    pulse(20, 20, 3);
    edges(8'h01, 8'h00, 8'h03);
    chk("a_c_fwd", 8'h01, {6'h00, ph[2], ph[0]});
    wreg(2'h0, 8'h03);
    rreg(2'h3, 8'h41);
    pulse(20, 20, 3);
    edges(8'h00, 8'h03, 8'h00);
    chk("a_c_rev", 8'h02, {6'h00, ph[2], ph[0]});
    chk("shoot", 8'h00, shoot);
    final_report;
end
endmodule // tb_top
bind cdb_bridge_deadband cdb_chk u_chk (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .src_i(src_i),
    .out_phase_a_o(out_phase_a_o), .out_phase_b_o(out_phase_b_o),
    .out_phase_c_o(out_phase_c_o), .out_phase_d_o(out_phase_d_o));
`default_nettype wire
